// [rtl/gqp_top.sv]
// Functional notes
// - Function zero connects pin to flash controller.
// - Software drives only in function five.
// - Software bits: clock, select, data 0-3.
// - Level conditions follow the pin level.
// - Rising and falling edges are detected.
// - Level conditions are never held.
// - Edges latch until software writes clear.
// - Enable, status, force for three destinations.
// - Wake destination line wakes the oscillators.
// - Six lines: two banks, three destinations.
// - Drive strength has four settings.
// - Slew rate is slow or fast.
// - Schmitt hysteresis can be enabled.
// - Separate pull-up and pull-down enables.
// - Input buffer can be disabled.
// - Function owns data and enable; register rest.
// - Output disable overrides the function enable.
// - Threshold bit one selects low-supply inputs.
// - Each pin has exactly one function.
// - Shared peripheral input sees OR of pins.
`timescale 1ns/1ns
`default_nettype none

module gqp_top (
  // Clock, reset and freeze
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [gqp_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [gqp_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Flash serial controller side
  input wire logic [gqp_pkg::NPIN-1:0] flash_out,
  input wire logic [gqp_pkg::NPIN-1:0] flash_oe,
  output logic [gqp_pkg::NPIN-1:0] flash_in,
  // Software pin control side
  input wire logic [gqp_pkg::NPIN-1:0] sw_out,
  input wire logic [gqp_pkg::NPIN-1:0] sw_oe,
  output logic [gqp_pkg::NPIN-1:0] sw_in,
  // User-bank per-destination status
  input wire logic [gqp_pkg::NDEST-1:0][gqp_pkg::UB_PINS-1:0] ub_status,
  // Pads
  input wire logic [gqp_pkg::NPIN-1:0] pad_in,
  output logic [gqp_pkg::NPIN-1:0] pad_out,
  output logic [gqp_pkg::NPIN-1:0] pad_oe,
  output gqp_pkg::gqp_pad_t [gqp_pkg::NPIN-1:0] pad_ctrl,
  output logic vsel_qspi,
  output logic vsel_user,
  // Interrupt lines: [2:0] user bank, [5:3] flash bank
  output logic [2*gqp_pkg::NDEST-1:0] irq
);
  import gqp_pkg::*;

  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  gqp_state_t s; // Registered state
  gqp_state_t n; // Next state
  logic [NPIN-1:0] in_v; // Synchronised, input-enable gated level
  logic [NPIN-1:0] rise; // Rising edge this cycle
  logic [NPIN-1:0] fall; // Falling edge this cycle
  logic [IRQ_W-1:0] raw; // Raw conditions
  logic [NDEST-1:0][IRQ_W-1:0] ints; // Per-destination status
  logic [NPIN-1:0] clr_lo; // Falling edges to clear
  logic [NPIN-1:0] clr_hi; // Rising edges to clear
  logic [31:0] wmask; // Byte-lane mask of the write
  logic [31:0] wnew; // Merged write word
  logic wr_fire; // Write performed this cycle
  gqp_sel_t wsel; // Decoded write target
  gqp_sel_t rsel; // Decoded read target

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Address to register kind and index
  function automatic gqp_sel_t reg_decode(input logic [ADDR_W-1:0] a);
    gqp_sel_t r;
    r.kind = SEL_NONE;
    r.idx = a[4:2];
    if (a[1:0] != 2'h0)
      r.kind = SEL_NONE;
    else if (a < OFF_PAD0)
    begin
      if (a[4:2] < 3'(NPIN) && a[5] == 1'b0)
        r.kind = SEL_CTRL;
    end
    else if (a < OFF_VSEL)
    begin
      if (a[4:2] < 3'(NPIN) && a[5] == 1'b1)
        r.kind = SEL_PAD;
    end
    else if (a == OFF_VSEL)
      r.kind = SEL_VSEL;
    else if (a == OFF_INTR)
      r.kind = SEL_INTR;
    else if (a == OFF_IN)
      r.kind = SEL_IN;
    else if (a < OFF_INTF0)
    begin
      r.kind = SEL_INTE;
      r.idx = 3'(8'(a - OFF_INTE0) >> 2);
    end
    else if (a < OFF_INTS0)
    begin
      r.kind = SEL_INTF;
      r.idx = 3'(8'(a - OFF_INTF0) >> 2);
    end
    else if (a < OFF_IN)
    begin
      r.kind = SEL_INTS;
      r.idx = 3'(8'(a - OFF_INTS0) >> 2);
    end
    return r;
  endfunction : reg_decode

  // Register contents as software sees them
  function automatic logic [31:0] rd_val(input gqp_sel_t r, input gqp_state_t st,
                                         input logic [IRQ_W-1:0] rw,
                                         input logic [NDEST-1:0][IRQ_W-1:0] is,
                                         input logic [NPIN-1:0] lv);
    logic [31:0] v;
    v = 32'h0;
    unique case (r.kind)
      SEL_CTRL: v = 32'(st.fsel[r.idx]);
      SEL_PAD: v = 32'(st.pad[r.idx]);
      SEL_VSEL:
      begin
        v[VSEL_QSPI_BIT] = st.vsel_qspi;
        v[VSEL_USER_BIT] = st.vsel_user;
      end
      SEL_INTR: v = 32'(rw);
      SEL_INTE: v = 32'(st.inte[r.idx[1:0]]);
      SEL_INTF: v = 32'(st.intf[r.idx[1:0]]);
      SEL_INTS: v = 32'(is[r.idx[1:0]]);
      SEL_IN: v = 32'(lv); // Pin levels, any function
      default: v = 32'h0;
    endcase
    return v;
  endfunction : rd_val

  // ----------------------------------------
  // Per-pin logic
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      // Disabled input buffer reads as zero
      assign in_v[gi] = s.sync2[gi] & s.pad[gi].ie;
      assign rise[gi] = in_v[gi] & ~s.prev[gi];
      assign fall[gi] = ~in_v[gi] & s.prev[gi];
      // Levels straight from the pin, never stored
      assign raw[4*gi+IRQ_LVL_LOW] = ~in_v[gi];
      assign raw[4*gi+IRQ_LVL_HIGH] = in_v[gi];
      assign raw[4*gi+IRQ_EDGE_LOW] = s.edge_lo[gi];
      assign raw[4*gi+IRQ_EDGE_HIGH] = s.edge_hi[gi];
      // Write-one-clear bits of the raw register
      assign clr_lo[gi] = wnew[4*gi+IRQ_EDGE_LOW] & wmask[4*gi+IRQ_EDGE_LOW];
      assign clr_hi[gi] = wnew[4*gi+IRQ_EDGE_HIGH] & wmask[4*gi+IRQ_EDGE_HIGH];
      // Output mux: one function per pin
      always_comb
      begin
        if (s.fsel[gi] == FSEL_FLASH)
        begin
          pad_out[gi] = flash_out[gi];
          pad_oe[gi] = flash_oe[gi] & ~s.pad[gi].od;
        end
        else if (s.fsel[gi] == FSEL_SW)
        begin
          pad_out[gi] = sw_out[gi];
          pad_oe[gi] = sw_oe[gi] & ~s.pad[gi].od;
        end
        else
        begin
          pad_out[gi] = 1'b0; // Unassigned slot drives nothing
          pad_oe[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt routing
  // ----------------------------------------
  genvar gd;
  generate
    for (gd = 0; gd < NDEST; gd++)
    begin : g_dest
      assign ints[gd] = (raw & s.inte[gd]) | s.intf[gd];
      assign irq[gd] = |ub_status[gd];
      // Line 5 is the oscillator wake request
      assign irq[NDEST+gd] = |ints[gd];
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Inputs reach every function at all times
  assign sw_in = in_v;
  // Each flash input has one pin, so the OR is that pin
  assign flash_in = in_v;
  assign pad_ctrl = s.pad;
  assign vsel_qspi = s.vsel_qspi;
  assign vsel_user = s.vsel_user;
  // Bus handshakes
  assign awready = ce & ~s.aw_got & ~s.bvalid;
  assign wready = ce & ~s.w_got & ~s.bvalid;
  assign arready = ce & ~s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

  // ----------------------------------------
  // Write merge
  // ----------------------------------------
  assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;
  assign wsel = reg_decode(s.awaddr);
  assign rsel = reg_decode(araddr);
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[8*gi +: 8] = {8{s.wstrb[gi]}};
    end
  endgenerate
  assign wnew = (rd_val(wsel, s, raw, ints, in_v) & ~wmask) | (s.wdata & wmask);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = s;
    // Two-stage pin synchroniser
    n.sync1 = pad_in;
    n.sync2 = s.sync1;
    n.prev = in_v;
    // Capture address and data in either order
    if (awvalid && awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready)
      n.bvalid = 1'b0;
    // Perform the write once both halves are held
    if (wr_fire)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wsel.kind)
        SEL_CTRL: n.fsel[wsel.idx] = wnew[FSEL_W-1:0];
        SEL_PAD: n.pad[wsel.idx] = gqp_pad_t'(wnew[7:0]);
        SEL_VSEL:
        begin
          n.vsel_qspi = wnew[VSEL_QSPI_BIT];
          n.vsel_user = wnew[VSEL_USER_BIT];
        end
        SEL_INTR:
        begin
          n.edge_lo = s.edge_lo & ~clr_lo;
          n.edge_hi = s.edge_hi & ~clr_hi;
        end
        SEL_INTE: n.inte[wsel.idx[1:0]] = wnew[IRQ_W-1:0];
        SEL_INTF: n.intf[wsel.idx[1:0]] = wnew[IRQ_W-1:0];
        default: n.bvalid = 1'b1; // Read-only or unmapped: no effect
      endcase
    end
    // Edge latch after the clear, so a new edge wins
    n.edge_lo = n.edge_lo | fall;
    n.edge_hi = n.edge_hi | rise;
    // Read answer registered on the same edge that takes the address
    if (s.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd_val(rsel, s, raw, ints, in_v);
      n.rresp = (rsel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= ST_RST;
    else if (ce)
      s <= n;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pin held still with the clock running
  sequence s_steady;
    (ce && $stable(pad_in))[*3];
  endsequence

  // Both write halves taken together
  sequence s_wr_both;
    ce && awvalid && awready && wvalid && wready;
  endsequence

  property p_flash_route;
    s.fsel[PIN_CLK] == FSEL_FLASH && !pad_ctrl[PIN_CLK].od
      |-> pad_out[PIN_CLK] == flash_out[PIN_CLK] && pad_oe[PIN_CLK] == flash_oe[PIN_CLK];
  endproperty
  a_flash_route: assert property (p_flash_route)
    else $error("flash function not routed to pin");

  property p_no_drive;
    s.fsel[PIN_D0] != FSEL_SW && s.fsel[PIN_D0] != FSEL_FLASH |-> !pad_oe[PIN_D0];
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("pin driven outside flash or software function");

  property p_sw_in;
    s_steady ##0 (pad_ctrl[PIN_CS].ie && s.fsel[PIN_CS] != FSEL_SW)
      |-> sw_in[PIN_CS] == pad_in[PIN_CS];
  endproperty
  a_sw_in: assert property (p_sw_in)
    else $error("pin level not visible to software");

  property p_level;
    s_steady ##0 pad_ctrl[PIN_CLK].ie
      |-> raw[IRQ_LVL_HIGH] == pad_in[PIN_CLK] && raw[IRQ_LVL_LOW] == !pad_in[PIN_CLK];
  endproperty
  a_level: assert property (p_level)
    else $error("level condition does not follow pin");

  property p_edge_set;
    ce && (|rise) |=> (s.edge_hi & $past(rise)) == $past(rise);
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("rising edge not latched");

  property p_edge_hold;
    !(wr_fire && wsel.kind == SEL_INTR) |=> ($past(s.edge_lo) & ~s.edge_lo) == '0;
  endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("edge flag lost without a clear");

  property p_wake;
    irq[NDEST+DEST_WAKE] == |((raw & s.inte[DEST_WAKE]) | s.intf[DEST_WAKE]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake line disagrees with its status");

  property p_cpu0_force;
    s.intf[DEST_CPU0] != '0 |-> irq[NDEST+DEST_CPU0];
  endproperty
  a_cpu0_force: assert property (p_cpu0_force)
    else $error("forced status did not raise line");

  property p_ub_or;
    irq[DEST_CPU0] == (ub_status[DEST_CPU0] != '0);
  endproperty
  a_ub_or: assert property (p_ub_or)
    else $error("user bank line is not an OR");

  property p_od;
    pad_ctrl[PIN_D0].od |-> !pad_oe[PIN_D0];
  endproperty
  a_od: assert property (p_od)
    else $error("output disable did not stop driver");

  property p_bresp;
    s_wr_both ##1 ce |-> ##1 bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write answer not on second edge");

endmodule : gqp_top

`default_nettype wire

// [rtl/gqp_pkg.sv]
`default_nettype none

package gqp_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NPIN = 6;       // Flash-bank pins
  localparam int NDEST = 3;      // Interrupt destinations
  localparam int IRQ_W = 4 * NPIN; // Four condition bits per pin
  localparam int UB_PINS = 30;   // User-bank pins
  localparam int ADDR_W = 8;     // Register byte address width
  localparam int FSEL_W = 5;     // Function select field width

  // Pin order of the software bits, from the LSB
  localparam int PIN_CLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_D0 = 2;

  // Function select codes
  localparam logic [4:0] FSEL_FLASH = 5'h00; // flash_function_slot
  localparam logic [4:0] FSEL_SW = 5'h05;    // software_function_slot
  localparam logic [4:0] FSEL_RST = 5'h00;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_PAD0 = 8'h20;
  localparam logic [7:0] OFF_VSEL = 8'h40;
  localparam logic [7:0] OFF_INTR = 8'h44;
  localparam logic [7:0] OFF_INTE0 = 8'h48;
  localparam logic [7:0] OFF_INTF0 = 8'h54;
  localparam logic [7:0] OFF_INTS0 = 8'h60;
  localparam logic [7:0] OFF_IN = 8'h6c;

  // Field positions
  localparam int VSEL_QSPI_BIT = 0;
  localparam int VSEL_USER_BIT = 1;
  localparam int IRQ_LVL_LOW = 0;
  localparam int IRQ_LVL_HIGH = 1;
  localparam int IRQ_EDGE_LOW = 2;
  localparam int IRQ_EDGE_HIGH = 3;
  localparam int DEST_CPU0 = 0;
  localparam int DEST_WAKE = 2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Drive strength codes
  typedef enum logic [1:0] {
    DRV_2MA = 2'b00,
    DRV_4MA = 2'b01,
    DRV_8MA = 2'b10,
    DRV_12MA = 2'b11
  } gqp_drive_t;

  // Pad control word, bit 7 down to bit 0
  typedef struct packed {
    logic od;          // Output disable
    logic ie;          // Input enable
    gqp_drive_t drive; // Drive strength
    logic pu;          // Pull-up
    logic pd;          // Pull-down
    logic schmitt;     // Hysteresis
    logic slew;        // Fast slew
  } gqp_pad_t;

  localparam logic [7:0] PAD_RST = 8'h52;

  // Register kinds seen by the decoder
  typedef enum logic [3:0] {
    SEL_CTRL = 4'b0000,
    SEL_PAD = 4'b0001,
    SEL_VSEL = 4'b0010,
    SEL_INTR = 4'b0011,
    SEL_INTE = 4'b0100,
    SEL_INTF = 4'b0101,
    SEL_INTS = 4'b0110,
    SEL_IN = 4'b0111,
    SEL_NONE = 4'b1000
  } gqp_kind_t;

  typedef struct packed {
    gqp_kind_t kind;
    logic [2:0] idx;
  } gqp_sel_t;

  // Whole state of the block
  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] prev;
    logic [NPIN-1:0] edge_hi;
    logic [NPIN-1:0] edge_lo;
    logic [NPIN-1:0][FSEL_W-1:0] fsel;
    gqp_pad_t [NPIN-1:0] pad;
    logic vsel_qspi;
    logic vsel_user;
    logic [NDEST-1:0][IRQ_W-1:0] inte;
    logic [NDEST-1:0][IRQ_W-1:0] intf;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gqp_state_t;

  localparam gqp_state_t ST_RST = '{
    fsel: {NPIN{FSEL_RST}},
    pad: {NPIN{PAD_RST}},
    default: '0
  };

endpackage : gqp_pkg

`default_nettype wire

// [verif/gqp_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none

module gqp_pin_model (
  // Clock
  input wire logic aclk,
  // Design pad side
  input wire logic [gqp_pkg::NPIN-1:0] pad_out,
  input wire logic [gqp_pkg::NPIN-1:0] pad_oe,
  input wire gqp_pkg::gqp_pad_t [gqp_pkg::NPIN-1:0] pad_ctrl,
  // Board side drivers
  input wire logic [gqp_pkg::NPIN-1:0] ext_level,
  input wire logic [gqp_pkg::NPIN-1:0] ext_en,
  // Level seen at the pad input
  output logic [gqp_pkg::NPIN-1:0] pad_in
);
  import gqp_pkg::*;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // Floating level, flips each cycle so a stale value never looks valid
  logic [NPIN-1:0] drift = '0;

  // Advance the floating pattern
  always @(posedge aclk)
  begin
    drift <= ~drift;
  end

  // Design driver first, then board driver, then pulls, else floating
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_level[i] :
                  pad_ctrl[i].pu ? 1'b1 : pad_ctrl[i].pd ? 1'b0 : drift[i];
    end
  end
endmodule : gqp_pin_model

`default_nettype wire

// [verif/tb_gqp_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_gqp_top;
  import gqp_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NPIN-1:0] flash_out = '0, flash_oe = '0, sw_out = '0, sw_oe = '0;
  logic [NPIN-1:0] flash_in, sw_in, pad_in, pad_out, pad_oe;
  logic [NDEST-1:0][UB_PINS-1:0] ub_status = '0;
  gqp_pad_t [NPIN-1:0] pad_ctrl;
  logic vsel_qspi, vsel_user;
  logic [2*NDEST-1:0] irq;
  // Board drivers of the pins
  logic [NPIN-1:0] ext_level = '0, ext_en = '1;
  // Bench bookkeeping
  int mismatches = 0, samples_checked = 0;
  logic [33:0] exp_q[$]; // Expected {resp, data} of each bus answer
  logic [NPIN-1:0] lv, nl, eo, ee;
  logic [23:0] m, f, st;
  logic [7:0] b;
  logic [31:0] r;
  logic [4:0] fs_tab [3] = '{FSEL_SW, 5'h03, FSEL_FLASH};

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // ----------------------------------------
  // Design and pin model
  // ----------------------------------------
  gqp_top i_gqp_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .flash_out(flash_out), .flash_oe(flash_oe), .flash_in(flash_in),
    .sw_out(sw_out), .sw_oe(sw_oe), .sw_in(sw_in), .ub_status(ub_status),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ctrl(pad_ctrl),
    .vsel_qspi(vsel_qspi), .vsel_user(vsel_user), .irq(irq));

  gqp_pin_model i_gqp_pin_model (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_ctrl(pad_ctrl), .ext_level(ext_level), .ext_en(ext_en), .pad_in(pad_in));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  // Count one comparison, report a difference
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp

  // Print counts and verdict, end the run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Bound every wait
  task automatic tick(inout int n);
    n++;
    if (n > 200)
    begin
      mismatches++;
      give_verdict();
    end
  endtask : tick

  // Take the oldest expectation whenever an answer is handed over
  always @(posedge aclk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      if (exp_q.size() == 0)
      begin
        mismatches++;
        $display("mismatch at %0t: expected %h got %h", $time, 34'h0, {rresp, rdata});
      end
      else
        cmp(exp_q.pop_front(), (bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata});
    end
  end

  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  // Write one word, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    exp_q.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      tick(n);
      if (awready && !ad)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge aclk);
      tick(n);
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  // Read one word and note the expected answer
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    exp_q.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      tick(n);
    end while (!arready);
    arvalid <= 1'b0;
    do
    begin
      @(posedge aclk);
      tick(n);
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // Raw word from pin levels and latched edges
  function automatic logic [23:0] raw_of(input logic [NPIN-1:0] p,
                                         input logic [NPIN-1:0] rs, input logic [NPIN-1:0] fl);
    raw_of = '0;
    for (int i = 0; i < NPIN; i++)
      raw_of[4*i +: 4] = {rs[i], fl[i], p[i], ~p[i]};
  endfunction : raw_of

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    r = $urandom(32'h7f18f4d7);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    rd(OFF_CTRL0, {27'h0, FSEL_RST}, RESP_OKAY);
    rd(OFF_PAD0, {24'h0, PAD_RST}, RESP_OKAY);
    rd(8'h80, 32'h0, RESP_SLVERR);
    wr(8'h80, $urandom, RESP_SLVERR);
    // Function selection steers the pads
    foreach (fs_tab[k])
    begin
      for (int i = 0; i < NPIN; i++)
        wr(OFF_CTRL0 + 8'(4*i), {27'h0, fs_tab[k]}, RESP_OKAY);
      flash_out <= 6'($urandom);
      flash_oe <= 6'($urandom);
      sw_out <= 6'($urandom);
      sw_oe <= 6'($urandom);
      @(negedge aclk);
      eo = (fs_tab[k] == FSEL_SW) ? sw_out : (fs_tab[k] == FSEL_FLASH) ? flash_out : '0;
      ee = (fs_tab[k] == FSEL_SW) ? sw_oe : (fs_tab[k] == FSEL_FLASH) ? flash_oe : '0;
      cmp(34'(eo), 34'(pad_out));
      cmp(34'(ee), 34'(pad_oe));
      rd(OFF_CTRL0 + 8'h08, {27'h0, fs_tab[k]}, RESP_OKAY);
    end
    // Pad settings, with output disable against a driving function
    flash_oe <= '1;
    for (int i = 0; i < NPIN; i++)
    begin
      b = 8'($urandom) | 8'h80;
      wr(OFF_PAD0 + 8'(4*i), {24'h0, b}, RESP_OKAY);
      cmp(34'(b), 34'(pad_ctrl[i]));
      rd(OFF_PAD0 + 8'(4*i), {24'h0, b}, RESP_OKAY);
    end
    cmp(34'(0), 34'(pad_oe));
    for (int i = 0; i < NPIN; i++)
    begin
      wr(OFF_PAD0 + 8'(4*i), {24'h0, PAD_RST}, RESP_OKAY);
      wr(OFF_CTRL0 + 8'(4*i), 32'h3, RESP_OKAY);
    end
    // Input levels, level conditions and latched edges
    lv = 6'($urandom);
    nl = 6'($urandom);
    ext_level <= lv;
    repeat (4) @(posedge aclk);
    wr(OFF_INTR, 32'hffffff, RESP_OKAY);
    cmp(34'(lv), 34'(sw_in));
    cmp(34'(lv), 34'(flash_in));
    rd(OFF_IN, {26'h0, lv}, RESP_OKAY);
    rd(OFF_INTR, {8'h0, raw_of(lv, '0, '0)}, RESP_OKAY);
    ext_level <= nl;
    repeat (4) @(posedge aclk);
    rd(OFF_INTR, {8'h0, raw_of(nl, nl & ~lv, lv & ~nl)}, RESP_OKAY);
    ext_level <= lv;
    repeat (4) @(posedge aclk);
    rd(OFF_INTR, {8'h0, raw_of(lv, lv ^ nl, lv ^ nl)}, RESP_OKAY);
    wr(OFF_INTR, 32'hffffff, RESP_OKAY);
    rd(OFF_INTR, {8'h0, raw_of(lv, '0, '0)}, RESP_OKAY);
    // Pulls on a released pin, then a disabled input buffer
    ext_en <= 6'h1f;
    wr(OFF_PAD0 + 8'h14, {24'h0, PAD_RST | 8'h08}, RESP_OKAY);
    repeat (3) @(posedge aclk);
    rd(OFF_IN, {26'h0, 1'b1, lv[4:0]}, RESP_OKAY);
    wr(OFF_PAD0 + 8'h14, {24'h0, PAD_RST | 8'h04}, RESP_OKAY);
    repeat (3) @(posedge aclk);
    rd(OFF_IN, {26'h0, 1'b0, lv[4:0]}, RESP_OKAY);
    wr(OFF_PAD0, {24'h0, PAD_RST & 8'hbf}, RESP_OKAY);
    repeat (3) @(posedge aclk);
    rd(OFF_IN, {26'h0, 1'b0, lv[4:1], 1'b0}, RESP_OKAY);
    wr(OFF_PAD0, {24'h0, PAD_RST}, RESP_OKAY);
    wr(OFF_PAD0 + 8'h14, {24'h0, PAD_RST}, RESP_OKAY);
    ext_en <= '1;
    repeat (4) @(posedge aclk);
    wr(OFF_INTR, 32'hffffff, RESP_OKAY);
    // Enable, force and status per destination, and the six lines
    for (int d = 0; d < NDEST; d++)
    begin
      ub_status[d] <= (d == 1) ? '0 : 30'($urandom);
      m = 24'($urandom);
      f = 24'($urandom) & 24'h888888;
      st = (raw_of(lv, '0, '0) & m) | f;
      wr(OFF_INTE0 + 8'(4*d), {8'h0, m}, RESP_OKAY);
      wr(OFF_INTF0 + 8'(4*d), {8'h0, f}, RESP_OKAY);
      wr(OFF_INTS0 + 8'(4*d), 32'hffffffff, RESP_OKAY);
      rd(OFF_INTS0 + 8'(4*d), {8'h0, st}, RESP_OKAY);
      cmp(34'(|st), 34'(irq[3+d]));
      cmp(34'(|ub_status[d]), 34'(irq[d]));
      wr(OFF_INTE0 + 8'(4*d), 32'h0, RESP_OKAY);
      wr(OFF_INTF0 + 8'(4*d), 32'h0, RESP_OKAY);
      cmp(34'(0), 34'(irq[3+d]));
    end
    // Threshold selects of both banks
    for (int v = 0; v < 4; v++)
    begin
      wr(OFF_VSEL, 32'(v), RESP_OKAY);
      cmp(34'(v), 34'({vsel_user, vsel_qspi}));
    end
    rd(OFF_VSEL, 32'h3, RESP_OKAY);
    // One byte strobe merges only its lane into the enable word
    wstrb <= 4'h2;
    wr(OFF_INTE0, 32'hffffffff, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_INTE0, 32'h0000ff00, RESP_OKAY);
    wr(OFF_INTE0, 32'h0, RESP_OKAY);
    // Freeze drops the readies
    ce <= 1'b0;
    @(negedge aclk);
    cmp(34'(0), 34'({awready, wready, arready}));
    @(posedge aclk);
    ce <= 1'b1;
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_VSEL, 32'h0, RESP_OKAY);
    cmp(34'(PAD_RST), 34'(pad_ctrl[0]));
    give_verdict();
  end
endmodule : tb_gqp_top

`default_nettype wire
